// ### spmi_switch_end.sv
// spmi_switch_end: switch side of the port 0 ingress pins
// assumes pins are asynchronous to clk; the mode and isolate inputs
// come from logic on clk and are read without synchronisers
`timescale 1ns/1ps
`default_nettype none
module spmi_switch_end #(
  parameter int HALF_CYC = spmi_pkg::REF_HALF_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  spmi_link_if.switch_mp            link,
  input  wire spmi_pkg::spmi_mode_e port_mode,
  input  wire logic                 virtual_phy_isolate,
  output logic                      rx_valid,
  input  wire logic                 rx_ready,
  output logic [3:0]                rx_data,
  output logic                      rx_err,
  output logic                      rx_abort,
  output logic                      rx_last,
  output logic                      overflow
);

  typedef enum logic [1:0] {CAP_IDLE, CAP_RECV, CAP_DROP} spmi_cap_e;

  localparam int PW = spmi_pkg::PIN_W;
  localparam int WW = spmi_pkg::WORD_W;

  logic          mac, mii_phy, rmii, pins_on;
  logic [PW-1:0] pin_raw;
  logic [PW-1:0] s1_q, s2_q, s3_q, filt_q, filt_d;
  logic          rise, in_valid, in_err;
  logic [3:0]    in_data;

  logic [spmi_pkg::DIV_W-1:0] div_q, div_d;
  logic          lvl_q, lvl_d, wrap;

  spmi_cap_e     st_q, st_d;
  logic          half_q, half_d, ferr_q, ferr_d;
  logic [1:0]    low_q, low_d;
  logic          pend_v_q, pend_v_d, ovf_q, ovf_d;
  logic [WW-1:0] pend_q, pend_d, word;
  logic          push, take, buf_rdy;
  logic [WW-1:0] out_word;

  // mode decode
  assign mac     = port_mode == spmi_pkg::SPMI_MII_MAC;
  assign mii_phy = port_mode == spmi_pkg::SPMI_MII_PHY;
  assign rmii    = port_mode == spmi_pkg::SPMI_RMII_PHY;

  // isolate only applies when the partner is a mac
  assign pins_on = mac | ~virtual_phy_isolate;

  // input buffers off: data, valid and error read as pulled low
  always_comb
  begin
    pin_raw = '0;
    pin_raw[spmi_pkg::PIN_CLK]  = link.port0_in_ref_clock;
    pin_raw[spmi_pkg::PIN_VALID] = link.port0_in_valid_line & pins_on;
    pin_raw[spmi_pkg::PIN_ERR]  = link.port0_in_error_line & pins_on;
    pin_raw[spmi_pkg::PIN_D_LSB +: 4] = link.port0_in_nibble & {4{pins_on}};
  end

  // agreement filter on the second and third stages
  always_comb
  begin
    filt_d = filt_q;
    for (int i = 0; i < PW; i++)
      filt_d[i] = spmi_pkg::spmi_agree(s2_q[i], s3_q[i], filt_q[i]);
  end

  // all lines share one pipeline, so data stays aligned to the clock
  assign rise     = filt_d[spmi_pkg::PIN_CLK] & ~filt_q[spmi_pkg::PIN_CLK];
  assign in_valid = filt_d[spmi_pkg::PIN_VALID];
  assign in_err   = filt_d[spmi_pkg::PIN_ERR];
  assign in_data  = filt_d[spmi_pkg::PIN_D_LSB +: 4];

  // in mii phy mode the switch makes the reference clock
  assign wrap  = div_q == spmi_pkg::DIV_W'(HALF_CYC - 1);
  assign div_d = wrap ? '0 : div_q + 1'b1;
  assign lvl_d = wrap ? ~lvl_q : lvl_q;
  assign link.ref_sw_o  = lvl_q;
  assign link.ref_sw_oe = mii_phy & ~virtual_phy_isolate;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      filt_q <= '0;
      div_q  <= '0;
      lvl_q  <= 1'b0;
    end
    else
    begin
      s1_q   <= pin_raw;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= filt_d;
      div_q  <= div_d;
      lvl_q  <= lvl_d;
    end
  end

  // capture state machine: one step per rising reference edge
  always_comb
  begin
    st_d     = st_q;
    half_d   = half_q;
    low_d    = low_q;
    ferr_d   = ferr_q;
    pend_v_d = pend_v_q & ~buf_rdy;
    pend_d   = pend_q;
    ovf_d    = 1'b0;
    push     = 1'b0;
    take     = 1'b0;
    word     = '0;
    if (rise)
    begin
      case (st_q)
        CAP_IDLE:
        begin
          if (in_valid)
          begin
            st_d = CAP_RECV;
            take = 1'b1;
          end
        end
        CAP_RECV:
        begin
          if (in_valid)
            take = 1'b1;
          else
          begin
            // frame end marker carries the frame's error summary
            word[spmi_pkg::WD_LAST] = 1'b1;
            word[spmi_pkg::WD_ERR]  = ferr_q;
            push   = 1'b1;
            st_d   = CAP_IDLE;
            half_d = 1'b0;
            ferr_d = 1'b0;
          end
        end
        CAP_DROP:
        begin
          // rest of an aborted packet is thrown away
          if (!in_valid)
            st_d = CAP_IDLE;
        end
        default:
        begin
          st_d = CAP_IDLE;
        end
      endcase
      if (take)
      begin
        if (mii_phy && in_err)
        begin
          word[spmi_pkg::WD_ABORT] = 1'b1;
          push   = 1'b1;
          st_d   = CAP_DROP;
          half_d = 1'b0;
          ferr_d = 1'b0;
        end
        else if (rmii)
        begin
          // error line never looked at here
          if (!half_q)
          begin
            low_d  = in_data[1:0];
            half_d = 1'b1;
          end
          else
          begin
            word[spmi_pkg::WD_LSB +: 4] = {in_data[1:0], low_q};
            push   = 1'b1;
            half_d = 1'b0;
          end
        end
        else
        begin
          word[spmi_pkg::WD_LSB +: 4] = in_data;
          word[spmi_pkg::WD_ERR]      = mac & in_err;
          ferr_d = ferr_q | (mac & in_err);
          push   = 1'b1;
        end
      end
    end
    // isolation cuts a frame short without a marker
    if (!pins_on)
    begin
      st_d   = CAP_IDLE;
      half_d = 1'b0;
      ferr_d = 1'b0;
      push   = 1'b0;
    end
    // the pins cannot be stalled: a word with no room is lost and flagged
    if (push)
    begin
      if (pend_v_q && !buf_rdy)
        ovf_d = 1'b1;
      else
      begin
        pend_v_d = 1'b1;
        pend_d   = word;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q     <= CAP_IDLE;
      half_q   <= 1'b0;
      low_q    <= 2'h0;
      ferr_q   <= 1'b0;
      pend_v_q <= 1'b0;
      pend_q   <= '0;
      ovf_q    <= 1'b0;
    end
    else
    begin
      st_q     <= st_d;
      half_q   <= half_d;
      low_q    <= low_d;
      ferr_q   <= ferr_d;
      pend_v_q <= pend_v_d;
      pend_q   <= pend_d;
      ovf_q    <= ovf_d;
    end
  end

  // two words of slack plus the pending word; a longer receiver stall loses words and flags overflow
  spmi_buf2 #(
    .W     (WW),
    .DEPTH (spmi_pkg::BUF_DEPTH)
  ) u_buf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (pend_v_q),
    .in_ready  (buf_rdy),
    .in_data   (pend_q),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (out_word)
  );

  // word fields to the receive logic
  assign rx_data  = out_word[spmi_pkg::WD_LSB +: 4];
  assign rx_err   = out_word[spmi_pkg::WD_ERR];
  assign rx_abort = out_word[spmi_pkg::WD_ABORT];
  assign rx_last  = out_word[spmi_pkg::WD_LAST];
  assign overflow = ovf_q;

endmodule
`default_nettype wire

// ### spmi_pkg.sv
// spmi_pkg: constants and helpers for the port 0 ingress link
// assumes one 50 MHz clock shared by the switch end and the partner end
// Overview of operation
// - mii mac: phy receive nibble is frame data
// - mii phy: mac transmit nibble is switched data
// - rmii phy: only bits one, zero carry data
// - mii mac: valid line qualifies nibble and error
// - mii phy: valid line qualifies nibble and error
// - mii mac: error line marks receive error
// - mii phy: error line aborts current packet
// - rmii phy: error line ignored
// - phy modes: isolate disables data, valid, error inputs
// - lines timed by port reference clock
package spmi_pkg;

  typedef enum logic [1:0] {SPMI_MII_MAC, SPMI_MII_PHY, SPMI_RMII_PHY} spmi_mode_e;

  // reference clock half period, kept slow enough for three-flop sampling
  localparam int CLK_PERIOD_NS = 20;
  localparam int REF_HALF_NS   = 200;
  localparam int REF_HALF_CYC  = (REF_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_W         = 8;

  // sampled pin vector layout
  localparam int PIN_D_LSB = 0;
  localparam int PIN_VALID = 4;
  localparam int PIN_ERR   = 5;
  localparam int PIN_CLK   = 6;
  localparam int PIN_W     = 7;

  // word layout handed to the receive logic
  localparam int NIB_W    = 4;
  localparam int WD_LSB   = 0;
  localparam int WD_ERR   = 4;
  localparam int WD_ABORT = 5;
  localparam int WD_LAST  = 6;
  localparam int WORD_W   = 7;

  localparam int BUF_DEPTH = 2;

  // a synchronised bit only moves once the second and third stages agree
  function automatic logic spmi_agree(input logic s2, input logic s3, input logic old);
    spmi_agree = (s2 == s3) ? s3 : old;
  endfunction

endpackage

// ### spmi_link_if.sv
// spmi_link_if: port 0 ingress pins between partner and switch
// assumes pull-downs on the one-way pins; the ref clock is two-way
`timescale 1ns/1ps
`default_nettype none
interface spmi_link_if ();

  logic [3:0] port0_in_nibble;
  logic       port0_in_valid_line;
  logic       port0_in_error_line;
  logic       ref_sw_o;
  logic       ref_sw_oe;
  logic       ref_pt_o;
  logic       ref_pt_oe;
  logic       port0_in_ref_clock;

  // wire level of the clock pin; pull-down when nobody drives
  assign port0_in_ref_clock = ref_sw_oe ? ref_sw_o : (ref_pt_oe & ref_pt_o);

  modport switch_mp (
    input  port0_in_nibble,
    input  port0_in_valid_line,
    input  port0_in_error_line,
    input  port0_in_ref_clock,
    output ref_sw_o,
    output ref_sw_oe
  );

  modport partner_mp (
    output port0_in_nibble,
    output port0_in_valid_line,
    output port0_in_error_line,
    input  port0_in_ref_clock,
    output ref_pt_o,
    output ref_pt_oe
  );

endinterface
`default_nettype wire

// ### spmi_buf2.sv
// spmi_buf2: small valid/ready buffer between capture and receive logic
// assumes DEPTH is a power of two; one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module spmi_buf2 #(
  parameter int W     = spmi_pkg::WORD_W,
  parameter int DEPTH = spmi_pkg::BUF_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem_q [DEPTH];
  logic [W-1:0]  mem_d [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          push, pop;

  // honest full and empty straight from the count
  assign in_ready  = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // next pointers, count and storage
  always_comb
  begin
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    if (push)
    begin
      mem_d[wr_q] = in_data;
      wr_d        = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
    end
    if (pop)
      rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= '0;
    end
    else
    begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
      mem_q <= mem_d;
    end
  end

endmodule
`default_nettype wire

// ### spmi_partner_end.sv
// spmi_partner_end: external phy or mac driving the port 0 ingress pins
// assumes the user keeps words coming within a frame; a gap ends it
`timescale 1ns/1ps
`default_nettype none
module spmi_partner_end #(
  parameter int HALF_CYC = spmi_pkg::REF_HALF_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  spmi_link_if.partner_mp           link,
  input  wire spmi_pkg::spmi_mode_e port_mode,
  input  wire logic                 tx_valid,
  output logic                      tx_ready,
  input  wire logic [3:0]           tx_data,
  input  wire logic                 tx_err,
  input  wire logic                 tx_last
);

  logic                     drive_clk, rmii, fall, wrap, consume;
  logic [spmi_pkg::DIV_W-1:0] cnt_q, cnt_d;
  logic                     lvl_q, lvl_d;
  logic                     s1_q, s2_q, s3_q, filt_q, filt_d;
  logic [3:0]               nib_q, nib_d, hold_q, hold_d;
  logic                     val_q, val_d, er_q, er_d, half_q, half_d, gap_q, gap_d;
  logic                     hold_v_q, hold_v_d, hold_e_q, hold_e_d, hold_l_q, hold_l_d;

  // the partner makes the clock in mii mac and rmii phy modes; in mii phy mode the switch makes it
  assign drive_clk      = port_mode != spmi_pkg::SPMI_MII_PHY;
  assign rmii           = port_mode == spmi_pkg::SPMI_RMII_PHY;
  assign link.ref_pt_o  = lvl_q;
  assign link.ref_pt_oe = drive_clk;
  assign link.port0_in_nibble     = nib_q;
  assign link.port0_in_valid_line = val_q;
  assign link.port0_in_error_line = er_q;
  assign tx_ready       = ~hold_v_q;

  // own divider, plus three-flop sampling of a clock made by the switch
  assign wrap   = cnt_q == spmi_pkg::DIV_W'(HALF_CYC - 1);
  assign cnt_d  = wrap ? '0 : cnt_q + 1'b1;
  assign lvl_d  = wrap ? ~lvl_q : lvl_q;
  assign filt_d = spmi_pkg::spmi_agree(s2_q, s3_q, filt_q);
  // launch on the falling edge so lines are settled at the rise
  assign fall   = drive_clk ? (lvl_q & wrap) : (filt_q & ~filt_d);

  // hold word and line drive
  always_comb
  begin
    hold_v_d = hold_v_q;
    hold_d   = hold_q;
    hold_e_d = hold_e_q;
    hold_l_d = hold_l_q;
    nib_d    = nib_q;
    val_d    = val_q;
    er_d     = er_q;
    half_d   = half_q;
    gap_d    = gap_q;
    consume  = 1'b0;
    if (tx_valid && tx_ready)
    begin
      hold_v_d = 1'b1;
      hold_d   = tx_data;
      hold_e_d = tx_err;
      hold_l_d = tx_last;
    end
    if (fall)
    begin
      if (gap_q || !hold_v_q)
      begin
        // one idle clock after a last word separates frames
        val_d  = 1'b0;
        nib_d  = 4'h0;
        er_d   = 1'b0;
        gap_d  = 1'b0;
        half_d = 1'b0;
      end
      else if (rmii)
      begin
        val_d   = 1'b1;
        nib_d   = half_q ? {2'h0, hold_q[3:2]} : {2'h0, hold_q[1:0]};
        // unused pin in rmii: whatever level is left here must be ignored
        er_d    = hold_e_q;
        consume = half_q;
        half_d  = ~half_q;
      end
      else
      begin
        val_d   = 1'b1;
        nib_d   = hold_q;
        er_d    = hold_e_q;
        consume = 1'b1;
      end
      if (consume)
      begin
        hold_v_d = 1'b0;
        gap_d    = hold_l_q;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_q    <= '0;
      lvl_q    <= 1'b0;
      s1_q     <= 1'b0;
      s2_q     <= 1'b0;
      s3_q     <= 1'b0;
      filt_q   <= 1'b0;
      hold_v_q <= 1'b0;
      hold_q   <= 4'h0;
      hold_e_q <= 1'b0;
      hold_l_q <= 1'b0;
      nib_q    <= 4'h0;
      val_q    <= 1'b0;
      er_q     <= 1'b0;
      half_q   <= 1'b0;
      gap_q    <= 1'b0;
    end
    else
    begin
      cnt_q    <= cnt_d;
      lvl_q    <= lvl_d;
      s1_q     <= link.port0_in_ref_clock;
      s2_q     <= s1_q;
      s3_q     <= s2_q;
      filt_q   <= filt_d;
      hold_v_q <= hold_v_d;
      hold_q   <= hold_d;
      hold_e_q <= hold_e_d;
      hold_l_q <= hold_l_d;
      nib_q    <= nib_d;
      val_q    <= val_d;
      er_q     <= er_d;
      half_q   <= half_d;
      gap_q    <= gap_d;
    end
  end

endmodule
`default_nettype wire

// ### spmi_link_props.sv
// spmi_link_props: wire-level checks on the port 0 ingress link
// assumes one clk domain; mode changes only while rst is high
`timescale 1ns/1ps
`default_nettype none
module spmi_link_props (
  input wire logic                 clk,
  input wire logic                 rst,
  input wire spmi_pkg::spmi_mode_e port_mode,
  input wire logic                 virtual_phy_isolate,
  input wire logic [3:0]           port0_in_nibble,
  input wire logic                 port0_in_valid_line,
  input wire logic                 port0_in_error_line,
  input wire logic                 ref_sw_oe,
  input wire logic                 ref_pt_oe,
  input wire logic                 port0_in_ref_clock
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // eight cycles of one clock level; the half period is ten
  sequence ref_hi_run;
    port0_in_ref_clock [*8];
  endsequence
  sequence ref_lo_run;
    !port0_in_ref_clock [*8];
  endsequence

  // clock pin ownership by mode
  AST_SW_OWNS_CLK: assert property (
    port_mode == spmi_pkg::SPMI_MII_PHY && !virtual_phy_isolate |-> ref_sw_oe && !ref_pt_oe)
    else $error("switch not driving ref clock in mii phy mode");
  AST_PT_OWNS_CLK: assert property (
    port_mode == spmi_pkg::SPMI_MII_MAC |-> ref_pt_oe && !ref_sw_oe)
    else $error("partner not driving ref clock in mii mac mode");
  AST_RMII_CLK: assert property (
    port_mode == spmi_pkg::SPMI_RMII_PHY |-> ref_pt_oe && !ref_sw_oe)
    else $error("ref clock owner wrong in rmii mode");
  AST_ISO_RELEASE: assert property (
    virtual_phy_isolate && port_mode != spmi_pkg::SPMI_MII_MAC |-> !ref_sw_oe)
    else $error("switch drives ref clock while isolated");
  // rmii error pin may carry junk inside a frame, but rests low between frames
  AST_RMII_ERR_IDLE: assert property (
    port_mode == spmi_pkg::SPMI_RMII_PHY && !port0_in_valid_line |-> !port0_in_error_line)
    else $error("error line active between rmii frames");
  // partner-clocked modes: lines move only with a falling clock edge
  AST_LINES_ON_FALL: assert property (
    port_mode != spmi_pkg::SPMI_MII_PHY
      && $changed({port0_in_nibble, port0_in_valid_line, port0_in_error_line})
      |-> $fell(port0_in_ref_clock))
    else $error("link lines changed away from a falling ref edge");
  AST_HI_HALF: assert property (
    $rose(port0_in_ref_clock) |-> ref_hi_run ##[2:4] $fell(port0_in_ref_clock))
    else $error("ref clock high phase has the wrong length");
  AST_LO_HALF: assert property (
    $fell(port0_in_ref_clock) && !virtual_phy_isolate
      |-> ref_lo_run ##[2:4] $rose(port0_in_ref_clock))
    else $error("ref clock low phase has the wrong length");
endmodule
`default_nettype wire

// ### tb.sv
// tb: partner end and switch end joined by the link interface
// assumes the design defaults for the ref half period; one clk
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                 clk;
  logic                 rst;
  logic                 iso;
  logic                 tx_valid;
  logic                 tx_err;
  logic                 tx_last;
  logic                 rx_ready;
  logic [3:0]           tx_data;
  spmi_pkg::spmi_mode_e port_mode;
  logic                 tx_ready;
  logic                 rx_valid;
  logic                 rx_err;
  logic                 rx_abort;
  logic                 rx_last;
  logic                 overflow;
  logic [3:0]           rx_data;
  logic [6:0]           got[$];
  logic [6:0]           exp[$];
  int                   fails;
  int                   num_checks;
  int                   cyc = 0;
  int                   ovf = 0;
  int                   o;

  spmi_link_if link ();
  spmi_partner_end spmi_partner_end_inst (.clk(clk), .rst(rst), .link(link.partner_mp),
    .port_mode(port_mode), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .tx_err(tx_err), .tx_last(tx_last));
  spmi_switch_end spmi_switch_end_inst (.clk(clk), .rst(rst), .link(link.switch_mp),
    .port_mode(port_mode), .virtual_phy_isolate(iso), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .rx_err(rx_err), .rx_abort(rx_abort),
    .rx_last(rx_last), .overflow(overflow));
  spmi_link_props spmi_link_props_inst (.clk(clk), .rst(rst), .port_mode(port_mode),
    .virtual_phy_isolate(iso), .port0_in_nibble(link.port0_in_nibble),
    .port0_in_valid_line(link.port0_in_valid_line),
    .port0_in_error_line(link.port0_in_error_line), .ref_sw_oe(link.ref_sw_oe),
    .ref_pt_oe(link.ref_pt_oe), .port0_in_ref_clock(link.port0_in_ref_clock));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // word seen = {last, abort, err, nibble}; an abort carries no data
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (rx_valid === 1'b1 && rx_ready === 1'b1)
      got.push_back(rx_abort === 1'b1 ? 7'h20 : {rx_last, 1'b0, rx_err, rx_data});
    if (overflow === 1'b1)
      ovf <= ovf + 1;
    if (cyc == 5000)
    begin
      fails++;
      final_report();
    end
  end

  task automatic chk_int(input string nm, input int e, input int g);
    num_checks++;
    if (e != g)
    begin
      fails++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic chk_word(input logic [6:0] e, input logic [6:0] g);
    num_checks++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] rx word expected %h seen %h", e, g);
    end
  endtask

  task automatic chk_words();
    chk_int("rx word count", exp.size(), got.size());
    for (int i = 0; i < exp.size() && i < got.size(); i++)
      chk_word(exp[i], got[i]);
    exp.delete();
  endtask

  // one word per handshake; wait for the hold slot to free again
  task automatic send(input int n, input logic [15:0] nib, input logic [3:0] er);
    int k;
    for (int i = 0; i < n; i++)
    begin
      tx_valid <= 1'b1;
      tx_data <= nib[4*i+:4];
      tx_err <= er[i];
      tx_last <= (i == n - 1);
      k = 0;
      do
      begin
        @(negedge clk);
        k++;
      end
      while (tx_ready !== 1'b1 && k < 500);
      @(posedge clk);
    end
    tx_valid <= 1'b0;
  endtask

  // quiet link and no pop for 60 cycles means the frame is done
  task automatic settle();
    int q;
    q = 0;
    while (q < 60)
    begin
      @(posedge clk);
      q = (link.port0_in_valid_line === 1'b0 && !(rx_valid === 1'b1 && rx_ready === 1'b1))
          ? q + 1 : 0;
    end
  endtask

  // mode and isolate only change under reset, so clocks restart clean
  task automatic run(input spmi_pkg::spmi_mode_e m, input logic is, input logic rdy,
                     input int n, input logic [15:0] nib, input logic [3:0] er);
    rst <= 1'b1;
    port_mode <= m;
    iso <= is;
    rx_ready <= rdy;
    repeat (3) @(posedge clk);
    got.delete();
    rst <= 1'b0;
    @(posedge clk);
    send(n, nib, er);
    settle();
  endtask

  initial
  begin
    rst = 1'b1;
    iso = 1'b0;
    tx_valid = 1'b0;
    tx_err = 1'b0;
    tx_last = 1'b0;
    rx_ready = 1'b0;
    tx_data = 4'h0;
    port_mode = spmi_pkg::SPMI_MII_MAC;
    fails = 0;
    num_checks = 0;
    run(spmi_pkg::SPMI_MII_MAC, 1'b0, 1'b1, 3, 16'h0c5a, 4'h2);
    exp = '{7'h0a, 7'h15, 7'h0c, 7'h50};
    chk_words();
    run(spmi_pkg::SPMI_MII_PHY, 1'b0, 1'b1, 2, 16'h0093, 4'h0);
    exp = '{7'h03, 7'h09, 7'h40};
    chk_words();
    run(spmi_pkg::SPMI_MII_PHY, 1'b0, 1'b1, 3, 16'h0421, 4'h2);
    exp = '{7'h01, 7'h20};
    chk_words();
    // error pin is held high through the rmii frame and must change nothing
    run(spmi_pkg::SPMI_RMII_PHY, 1'b0, 1'b1, 2, 16'h00b6, 4'h3);
    exp = '{7'h06, 7'h0b, 7'h40};
    chk_words();
    run(spmi_pkg::SPMI_RMII_PHY, 1'b1, 1'b1, 2, 16'h00b6, 4'h0);
    chk_words();
    // isolated mii phy: switch stops its clock, so nothing reaches the receiver
    run(spmi_pkg::SPMI_MII_PHY, 1'b1, 1'b1, 1, 16'h0005, 4'h0);
    chk_words();
    // stalled receiver: two buffered, one pending, the rest lost
    o = ovf;
    run(spmi_pkg::SPMI_MII_MAC, 1'b0, 1'b0, 4, 16'h4321, 4'h0);
    rx_ready <= 1'b1;
    settle();
    exp = '{7'h01, 7'h02, 7'h03};
    chk_words();
    chk_int("overflow pulses", 2, ovf - o);
    final_report();
  end
endmodule
`default_nettype wire
